// ==== stc_timer.sv ====
// sixteen-bit timer/counter with avalon-mm register slave
// Function
// (R1) Control bit 7 set gives buffered 16-bit count access; clear gives two byte accesses.
// (R2) Control bit 6 is read-only: 1 when system clock comes from timer oscillator.
// (R3) Prescale field divides input: 11 by 8, 10 by 4, 01 by 2, 00 by 1.
// (R4) Control bit 3 enables the crystal oscillator; clear shuts it off.
// (R5) External source: bit 2 set bypasses synchroniser, clear synchronises; ignored internally.
// (R6) Source bit 1 clear counts instruction cycles; set counts external or crystal rises.
// (R7) Counting happens only while run bit 0 is set.
// (R8) Crystal enabled: oscillator pins lose digital logic, direction ignored, read zero.
// (R9) Buffered mode: low byte read copies live high byte into buffer.
// (R10) Buffered mode: high write loads buffer; low write loads both bytes at once.
// (R11) Low byte write clears the prescaler; high byte write leaves it alone.
// (R12) Counter mode needs a falling edge before first counted rise after reset/write/disable.
// (R13) Crystal oscillator keeps running through all power-managed modes.
// (R14) Software picks crystal source only with internal or low-power primary clock.
// (R15) Count wraps FFFFh to 0000h and latches the overflow flag.
// (R16) Overflow flag raises interrupt only while its enable bit is set.
// (R17) Unbuffered mode accesses the live high byte directly, with no transfers.
// (R18) Synchronised mode uses two-stage synchroniser; asynchronous mode takes input directly.
//
// Chosen here: the Avalon-MM register port and the address map.
module stc_timer
  import stc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_count_input,
  input wire logic low_power_crystal_clock,
  input wire logic sysclk_from_timer_osc,
  input wire logic [1:0] osc_pin_in,
  input wire logic [1:0] port_a_direction,
  output logic crystal_osc_enable,
  output logic [1:0] osc_pin_read,
  output logic [1:0] osc_pin_oe,
  output logic irq
);

  if (CNT_W != 16) begin : g_width_check
    $error("stc_timer: only a 16-bit count is supported");
  end

  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic wide_access_mode;
    logic [1:0] input_prescale_select;
    logic crystal_osc_enable;
    logic external_sync_bypass;
    logic count_source_select;
    logic counter_run;
    logic [15:0] count;
    logic [7:0] high_buf;
    logic [2:0] presc;
    logic [1:0] instr_div;
    logic sync_a;
    logic sync_b;
    logic raw_samp;
    logic edge_prev;
    logic armed;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic irq;
    logic [1:0] pin_read;
    logic [1:0] pin_oe;
  } stc_state_t;

  stc_state_t q_ff;
  stc_state_t nxt_q;

  logic req;
  logic acc_rd;
  logic acc_wr;
  logic wr_low;
  logic wr_high;
  logic ext_level;
  logic ext_rise;
  logic ext_fall;
  logic instr_tick;
  logic src_tick;
  logic [2:0] presc_mask;
  logic count_inc;
  logic [7:0] ctrl_view;

  assign req = avs_read | avs_write;
  assign acc_rd = avs_read & ~q_ff.wait_req;
  assign acc_wr = avs_write & ~q_ff.wait_req & avs_byteenable[0];
  assign wr_low = acc_wr && (avs_address == STC_OFS_COUNT_LOW);
  assign wr_high = acc_wr && (avs_address == STC_OFS_COUNT_HIGH);

  // asynchronous mode skips the synchroniser so edges land one cycle earlier [R5] [R18]
  assign ext_level = q_ff.external_sync_bypass ? q_ff.raw_samp : q_ff.sync_b;
  assign ext_rise = ext_level & ~q_ff.edge_prev;
  assign ext_fall = ~ext_level & q_ff.edge_prev;
  assign instr_tick = (q_ff.instr_div == 2'(STC_INSTR_DIV - 1));

  // internal source: one tick per instruction cycle; external: armed rising edges [R6] [R12]
  assign src_tick = q_ff.count_source_select ? (ext_rise & q_ff.armed) : instr_tick;
  assign presc_mask = 3'((4'h1 << q_ff.input_prescale_select) - 4'h1); // [R3]
  assign count_inc = q_ff.counter_run & src_tick & (q_ff.presc == presc_mask); // [R7]

  assign ctrl_view = {q_ff.wide_access_mode, sysclk_from_timer_osc, // [R2]
                      q_ff.input_prescale_select, q_ff.crystal_osc_enable,
                      q_ff.external_sync_bypass, q_ff.count_source_select,
                      q_ff.counter_run};

  always_comb begin
    nxt_q = q_ff;

    // one wait cycle per access: read data is prepared while waitrequest is high
    nxt_q.wait_req = ~(req & q_ff.wait_req);
    if (req && q_ff.wait_req) begin
      nxt_q.rdata = 32'h0000_0000;
      case (avs_address)
        STC_OFS_CONTROL: nxt_q.rdata[7:0] = ctrl_view;
        STC_OFS_COUNT_LOW: nxt_q.rdata[7:0] = q_ff.count[7:0];
        STC_OFS_COUNT_HIGH: begin
          // buffered mode shows the buffer, else the live byte [R1] [R17]
          nxt_q.rdata[7:0] = q_ff.wide_access_mode ? q_ff.high_buf : q_ff.count[15:8];
        end
        STC_OFS_IRQ_FLAG: nxt_q.rdata[STC_BIT_OVERFLOW] = q_ff.overflow_flag;
        STC_OFS_IRQ_ENABLE: nxt_q.rdata[STC_BIT_OVERFLOW] = q_ff.overflow_irq_enable;
        default: nxt_q.rdata = 32'h0000_0000;
      endcase
    end

    // clock divider and input sampling run freely
    nxt_q.instr_div = instr_tick ? 2'h0 : q_ff.instr_div + 2'h1;
    nxt_q.sync_a = external_count_input;
    nxt_q.sync_b = q_ff.sync_a; // [R18]
    // crystal clock replaces the pin when the oscillator is on [R6]
    nxt_q.raw_samp = q_ff.crystal_osc_enable ? low_power_crystal_clock : external_count_input;
    if (q_ff.crystal_osc_enable) begin
      nxt_q.sync_a = low_power_crystal_clock;
    end
    nxt_q.edge_prev = ext_level;

    // falling edge arms the counter; disable drops the arm [R12]
    if (ext_fall) begin
      nxt_q.armed = 1'b1;
    end
    if (!q_ff.counter_run) begin
      nxt_q.armed = 1'b0;
    end

    // prescaler and count
    if (q_ff.counter_run && src_tick) begin
      nxt_q.presc = (q_ff.presc == presc_mask) ? 3'h0 : q_ff.presc + 3'h1; // [R3]
    end
    if (count_inc) begin
      nxt_q.count = q_ff.count + 16'h0001; // [R15]
    end

    // overflow: the set wins over a same-cycle clear
    if (acc_wr && avs_address == STC_OFS_IRQ_FLAG && avs_writedata[STC_BIT_OVERFLOW]) begin
      nxt_q.overflow_flag = 1'b0;
    end
    if (count_inc && q_ff.count == STC_COUNT_MAX) begin
      nxt_q.overflow_flag = 1'b1; // [R15]
    end

    // low byte read snapshots the live high byte [R9]
    if (acc_rd && avs_address == STC_OFS_COUNT_LOW && q_ff.wide_access_mode) begin
      nxt_q.high_buf = q_ff.count[15:8];
    end

    // software writes take precedence over a coincident increment
    if (acc_wr) begin
      case (avs_address)
        STC_OFS_CONTROL: begin
          nxt_q.wide_access_mode = avs_writedata[STC_BIT_WIDE_ACCESS]; // [R1]
          nxt_q.input_prescale_select =
            avs_writedata[STC_BIT_PRESCALE_HI:STC_BIT_PRESCALE_LO];
          nxt_q.crystal_osc_enable = avs_writedata[STC_BIT_OSC_ENABLE]; // [R4]
          nxt_q.external_sync_bypass = avs_writedata[STC_BIT_SYNC_BYPASS];
          nxt_q.count_source_select = avs_writedata[STC_BIT_SOURCE_SELECT];
          nxt_q.counter_run = avs_writedata[STC_BIT_RUN];
        end
        STC_OFS_COUNT_LOW: begin
          nxt_q.presc = 3'h0; // [R11]
          nxt_q.armed = 1'b0; // [R12]
          if (q_ff.wide_access_mode) begin
            nxt_q.count = {q_ff.high_buf, avs_writedata[7:0]}; // [R10]
          end else begin
            nxt_q.count[7:0] = avs_writedata[7:0];
          end
        end
        STC_OFS_COUNT_HIGH: begin
          nxt_q.armed = 1'b0; // [R12]
          if (q_ff.wide_access_mode) begin
            nxt_q.high_buf = avs_writedata[7:0]; // [R10]
          end else begin
            // live byte, prescaler untouched [R11] [R17]
            nxt_q.count[15:8] = avs_writedata[7:0];
          end
        end
        STC_OFS_IRQ_ENABLE: nxt_q.overflow_irq_enable = avs_writedata[STC_BIT_OVERFLOW];
        default: nxt_q.armed = nxt_q.armed;
      endcase
    end

    nxt_q.irq = nxt_q.overflow_flag & nxt_q.overflow_irq_enable; // [R16]

    // oscillator owns its pins: digital path off, reads zero [R8]
    nxt_q.pin_read = nxt_q.crystal_osc_enable ? 2'b00 : osc_pin_in;
    nxt_q.pin_oe = nxt_q.crystal_osc_enable ? 2'b00 : ~port_a_direction;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '0;
      q_ff.wait_req <= 1'b1;
      q_ff.wide_access_mode <= STC_RST_CONTROL[STC_BIT_WIDE_ACCESS];
      q_ff.input_prescale_select <= STC_RST_CONTROL[STC_BIT_PRESCALE_HI:STC_BIT_PRESCALE_LO];
      q_ff.crystal_osc_enable <= STC_RST_CONTROL[STC_BIT_OSC_ENABLE];
      q_ff.external_sync_bypass <= STC_RST_CONTROL[STC_BIT_SYNC_BYPASS];
      q_ff.count_source_select <= STC_RST_CONTROL[STC_BIT_SOURCE_SELECT];
      q_ff.counter_run <= STC_RST_CONTROL[STC_BIT_RUN];
      q_ff.count <= STC_RST_COUNT;
      q_ff.high_buf <= STC_RST_HIGH_BUF;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // only the enable drives this port; the oscillator has no power-mode input to stop it [R13]
  assign crystal_osc_enable = q_ff.crystal_osc_enable; // [R4]
  assign avs_readdata = q_ff.rdata;
  assign avs_waitrequest = q_ff.wait_req;
  assign osc_pin_read = q_ff.pin_read;
  assign osc_pin_oe = q_ff.pin_oe;
  assign irq = q_ff.irq;

  // checks on bus timing, counting, flags and pins
  a_wait_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (req && q_ff.wait_req) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");

  a_run_holds_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
    (!q_ff.counter_run && !acc_wr) |=> (q_ff.count == $past(q_ff.count)))
    else $error("count moved while stopped");

  a_overflow_wraps: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R15]
    (count_inc && q_ff.count == STC_COUNT_MAX && !acc_wr)
      |=> (q_ff.count == 16'h0000) && q_ff.overflow_flag)
    else $error("overflow did not wrap and set the flag");

  a_irq_masked: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R16]
    irq |-> (q_ff.overflow_flag && q_ff.overflow_irq_enable))
    else $error("interrupt without enabled flag");

  a_low_read_copy: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
    (acc_rd && avs_address == STC_OFS_COUNT_LOW && q_ff.wide_access_mode)
      |=> (q_ff.high_buf == $past(q_ff.count[15:8])))
    else $error("low byte read did not snapshot high byte");

  a_high_write_buf: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
    (wr_high && q_ff.wide_access_mode)
      |=> (q_ff.high_buf == $past(avs_writedata[7:0])))
    else $error("buffered high write missed the buffer");

  a_low_write_both: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
    (wr_low && q_ff.wide_access_mode)
      |=> (q_ff.count == {$past(q_ff.high_buf), $past(avs_writedata[7:0])}))
    else $error("buffered low write did not load both bytes");

  a_presc_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
    wr_low |=> (q_ff.presc == 3'h0))
    else $error("prescaler not cleared by low write");

  a_write_disarms: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R12]
    (wr_low || wr_high) |=> !q_ff.armed)
    else $error("counter stayed armed after a count write");

  a_pins_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
    q_ff.crystal_osc_enable |-> (osc_pin_read == 2'b00 && osc_pin_oe == 2'b00))
    else $error("oscillator pins not released");

  a_internal_rate: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
    (q_ff.counter_run && !q_ff.count_source_select && count_inc && !acc_wr)
      |=> !count_inc [*3])
    else $error("internal source counted faster than one per instruction");

  // the slave idles with waitrequest up, so a stray low means a phantom access
  a_wait_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !req |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  a_read_data_upper: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !avs_waitrequest |-> (avs_readdata[31:8] == 24'h00_0000))
    else $error("read data upper bits not zero");

  a_unmapped_read_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (req && q_ff.wait_req && avs_address > STC_OFS_IRQ_ENABLE)
      |=> (avs_readdata == 32'h0000_0000))
    else $error("unmapped address read nonzero");

  a_control_readback: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
    (avs_read && q_ff.wait_req && avs_address == STC_OFS_CONTROL)
      |=> (avs_readdata[STC_BIT_SYSCLK_FROM_OSC] == $past(sysclk_from_timer_osc)))
    else $error("clock status bit not shown on control read");

  a_control_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1] [R4] [R7]
    (acc_wr && avs_address == STC_OFS_CONTROL)
      |=> ((q_ff.wide_access_mode == $past(avs_writedata[STC_BIT_WIDE_ACCESS]))
        && (crystal_osc_enable == $past(avs_writedata[STC_BIT_OSC_ENABLE]))
        && (q_ff.counter_run == $past(avs_writedata[STC_BIT_RUN]))))
    else $error("control write did not land");

  // flag holds until software writes a one, and the set beats the clear
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R15]
    (q_ff.overflow_flag && !(acc_wr && avs_address == STC_OFS_IRQ_FLAG))
      |=> q_ff.overflow_flag)
    else $error("overflow flag dropped without a clear");

  a_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R15]
    (acc_wr && avs_address == STC_OFS_IRQ_FLAG && avs_writedata[STC_BIT_OVERFLOW]
      && !(count_inc && q_ff.count == STC_COUNT_MAX)) |=> !q_ff.overflow_flag)
    else $error("overflow flag survived a clear");

  a_irq_on_overflow: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R16]
    (count_inc && q_ff.count == STC_COUNT_MAX && q_ff.overflow_irq_enable && !acc_wr)
      |=> irq)
    else $error("enabled overflow raised no interrupt");

  a_mask_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R16]
    (acc_wr && avs_address == STC_OFS_IRQ_ENABLE)
      |=> (q_ff.overflow_irq_enable == $past(avs_writedata[STC_BIT_OVERFLOW])))
    else $error("interrupt enable write did not land");

  a_live_high_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R17]
    (wr_high && !q_ff.wide_access_mode)
      |=> (q_ff.count[15:8] == $past(avs_writedata[7:0])))
    else $error("unbuffered high write missed the count");

  a_unbuffered_low_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R17]
    (wr_low && !q_ff.wide_access_mode && !count_inc)
      |=> (q_ff.count == {$past(q_ff.count[15:8]), $past(avs_writedata[7:0])}))
    else $error("unbuffered low write touched the high byte");

  a_unbuffered_read_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R17]
    (acc_rd && avs_address == STC_OFS_COUNT_LOW && !q_ff.wide_access_mode)
      |=> (q_ff.high_buf == $past(q_ff.high_buf)))
    else $error("unbuffered low read moved the buffer");

  a_buffered_high_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
    (wr_high && q_ff.wide_access_mode && !count_inc)
      |=> (q_ff.count == $past(q_ff.count)))
    else $error("buffered high write changed the count");

  // a high write must not restart the prescale sequence
  a_high_keeps_presc: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
    (wr_high && !(q_ff.counter_run && src_tick)) |=> (q_ff.presc == $past(q_ff.presc)))
    else $error("high byte write moved the prescaler");

  a_stop_disarms: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R12]
    !q_ff.counter_run |=> !q_ff.armed)
    else $error("counter armed while stopped");

  c_overflow: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(q_ff.overflow_flag));
  c_buffered_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (acc_rd && avs_address == STC_OFS_COUNT_LOW && q_ff.wide_access_mode));
  c_external_count: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (count_inc && q_ff.count_source_select));
  c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(irq));
  c_crystal_count: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (count_inc && q_ff.crystal_osc_enable));

endmodule

// ==== stc_pkg.sv ====
// constants shared by the sixteen-bit timer/counter
package stc_pkg;
  // register byte addresses on the avalon slave
  localparam logic [4:0] STC_OFS_CONTROL = 5'h00;
  localparam logic [4:0] STC_OFS_COUNT_LOW = 5'h04;
  localparam logic [4:0] STC_OFS_COUNT_HIGH = 5'h08;
  localparam logic [4:0] STC_OFS_IRQ_FLAG = 5'h0C;
  localparam logic [4:0] STC_OFS_IRQ_ENABLE = 5'h10;

  // timer_one_control field positions
  localparam int STC_BIT_WIDE_ACCESS = 7;
  localparam int STC_BIT_SYSCLK_FROM_OSC = 6;
  localparam int STC_BIT_PRESCALE_HI = 5;
  localparam int STC_BIT_PRESCALE_LO = 4;
  localparam int STC_BIT_OSC_ENABLE = 3;
  localparam int STC_BIT_SYNC_BYPASS = 2;
  localparam int STC_BIT_SOURCE_SELECT = 1;
  localparam int STC_BIT_RUN = 0;

  // overflow flag and its enable share bit 0 of their registers
  localparam int STC_BIT_OVERFLOW = 0;

  // reset values
  localparam logic [7:0] STC_RST_CONTROL = 8'h00;
  localparam logic [15:0] STC_RST_COUNT = 16'h0000;
  localparam logic [7:0] STC_RST_HIGH_BUF = 8'h00;

  // count limits
  localparam logic [15:0] STC_COUNT_MAX = 16'hFFFF;

  // prescale field encodings
  localparam logic [1:0] STC_PS_DIV1 = 2'h0;
  localparam logic [1:0] STC_PS_DIV2 = 2'h1;
  localparam logic [1:0] STC_PS_DIV4 = 2'h2;
  localparam logic [1:0] STC_PS_DIV8 = 2'h3;

  // instruction cycle is four system clocks
  localparam int STC_INSTR_DIV = 4;
endpackage

// ==== stc_count_source.sv ====
// stand-in for the external count pin and the 32 kHz crystal
module stc_count_source (
  input wire logic sys_clk,
  input wire logic use_xtal,
  input wire logic start,
  input wire logic [7:0] pulses,
  output logic busy,
  output logic ext_clk,
  output logic xtal_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl = 1'b0;
  logic noise = 1'b0;
  // the unused line chatters, so a wrong source choice shows up in the count
  assign ext_clk = use_xtal ? noise : lvl;
  assign xtal_clk = use_xtal ? lvl : noise;
  initial busy = 1'b0;
  always @(posedge sys_clk) noise <= ~noise;
  // clock idles low between bursts; each pulse is rise then fall
  always begin
    @(posedge sys_clk);
    if (start) begin
      busy <= 1'b1;
      for (int i = 0; i < pulses; i++) begin
        lvl <= 1'b1;
        repeat (4) @(posedge sys_clk);
        lvl <= 1'b0;
        repeat (4) @(posedge sys_clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// ==== sixteen_bit_timer_counter_tb_top.sv ====
// self-checking bench for the sixteen-bit timer/counter
module sixteen_bit_timer_counter_tb_top
  import stc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n, avs_read, avs_write, avs_waitrequest, irq, crystal_osc_enable;
  logic use_xtal, start, busy, ext_clk, xtal_clk, xt, clk_stat;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] osc_pin_read, osc_pin_oe;
  logic [7:0] ctl;
  int fails = 0;
  int comparisons = 0;
  int n;
  always #5 sys_clk = ~sys_clk;
  stc_timer #(.CNT_W(16)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_count_input(ext_clk), .low_power_crystal_clock(xtal_clk),
    .sysclk_from_timer_osc(clk_stat), .osc_pin_in(2'h2), .port_a_direction(2'h1),
    .crystal_osc_enable(crystal_osc_enable), .osc_pin_read(osc_pin_read),
    .osc_pin_oe(osc_pin_oe), .irq(irq));
  stc_count_source src (.sys_clk(sys_clk), .use_xtal(use_xtal), .start(start),
    .pulses(8'h11), .busy(busy), .ext_clk(ext_clk), .xtal_clk(xtal_clk));
  task automatic close_out();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // holds the request until waitrequest is seen low, then one idle edge
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    avs_address <= a;
    avs_write <= we;
    avs_read <= ~we;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) begin
      fails++;
      $display("unexpected waitrequest: expected 0, seen %b", avs_waitrequest);
    end
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // upper readdata bits are unused and must read zero
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(what, {8'h00, exp}, q[15:0]);
    check("readdata upper", 16'h0000, q[31:16]);
  endtask
  task automatic check_irq(input string what, input logic exp);
    repeat (2) @(posedge sys_clk);
    check(what, {15'h0000, exp}, {15'h0000, irq});
  endtask
  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    use_xtal = 1'b0;
    start = 1'b0;
    clk_stat = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk("control", STC_OFS_CONTROL, 8'h40);
    rd_chk("unmapped", 5'h14, 8'h00);
    wr(STC_OFS_COUNT_HIGH, 8'h56);
    rd_chk("live high", STC_OFS_COUNT_HIGH, 8'h56);
    wr(STC_OFS_CONTROL, 8'h80);
    clk_stat <= 1'b0;
    rd_chk("control wide", STC_OFS_CONTROL, 8'h80);
    wr(STC_OFS_COUNT_HIGH, 8'h12);
    wr(STC_OFS_COUNT_LOW, 8'h34);
    wr(STC_OFS_COUNT_HIGH, 8'h99);
    rd_chk("low", STC_OFS_COUNT_LOW, 8'h34);
    rd_chk("buffered high", STC_OFS_COUNT_HIGH, 8'h12);
    // 17 pulses from idle low: the first rise is never counted
    for (int ps = 0; ps < 4; ps++) begin
      xt = (ps == 3);
      use_xtal <= xt;
      ctl = {2'h0, ps[1:0], xt, ps[0], 2'h0};
      wr(STC_OFS_CONTROL, ctl);
      wr(STC_OFS_COUNT_HIGH, 8'h00);
      wr(STC_OFS_COUNT_LOW, 8'h00);
      wr(STC_OFS_CONTROL, ctl | 8'h03);
      start <= 1'b1;
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (busy !== 1'b1 && n < 10);
      start <= 1'b0;
      do @(posedge sys_clk); while (busy !== 1'b0);
      repeat (4) @(posedge sys_clk);
      check("osc enable", {15'h0000, xt}, {15'h0000, crystal_osc_enable});
      check("pin read", xt ? 16'h0000 : 16'h0002, {14'h0000, osc_pin_read});
      check("pin oe", xt ? 16'h0000 : 16'h0002, {14'h0000, osc_pin_oe});
      wr(STC_OFS_CONTROL, ctl);
      rd_chk("pulse count", STC_OFS_COUNT_LOW, 8'h10 >> ps);
    end
    use_xtal <= 1'b0;
    wr(STC_OFS_CONTROL, 8'h00);
    wr(STC_OFS_COUNT_HIGH, 8'hFF);
    wr(STC_OFS_COUNT_LOW, 8'hFF);
    wr(STC_OFS_IRQ_ENABLE, 8'h01);
    wr(STC_OFS_CONTROL, 8'h01);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (irq !== 1'b1 && n < 40);
    check("overflow irq", 16'h0001, {15'h0000, irq});
    wr(STC_OFS_CONTROL, 8'h00);
    rd_chk("flag", STC_OFS_IRQ_FLAG, 8'h01);
    rd_chk("wrapped high", STC_OFS_COUNT_HIGH, 8'h00);
    wr(STC_OFS_IRQ_ENABLE, 8'h00);
    check_irq("masked irq", 1'b0);
    wr(STC_OFS_IRQ_ENABLE, 8'h01);
    check_irq("unmasked irq", 1'b1);
    wr(STC_OFS_IRQ_FLAG, 8'h01);
    check_irq("cleared irq", 1'b0);
    wr(STC_OFS_COUNT_LOW, 8'h00);
    repeat (20) @(posedge sys_clk);
    rd_chk("stopped count", STC_OFS_COUNT_LOW, 8'h00);
    close_out();
  end
  // whole run is about 750 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("unexpected watchdog: expected finish, seen timeout");
    close_out();
  end
endmodule
